// ---- rtl/slcd_pkg.sv ----
/*
  slcd_pkg: constants, register map and field layouts for the segment
  display controller.
  assumes: included before slcd_ctrl; APB byte addresses are four times
  the register index.
*/
package slcd_pkg;

  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_PIN_FUNC = 16'hf730;
  localparam logic [15:0] IDX_DRIVE_CTL = 16'hf731;
  localparam logic [15:0] IDX_WAVE_CTL = 16'hf732;
  localparam logic [15:0] IDX_CLK_ON = 16'hf733;
  localparam logic [15:0] IDX_STATUS = 16'hf734;
  localparam logic [15:0] IDX_RAM_FIRST = 16'hf740;
  localparam logic [15:0] IDX_RAM_LAST = 16'hf74f;

  localparam int RAM_BYTES = 16;
  localparam int SEG_PINS = 32;
  localparam int COMMONS = 4;
  localparam int SEG_GROUP = 4;

  // field positions
  localparam int PF_DUTY_HI = 7;
  localparam int PF_DUTY_LO = 6;
  localparam int PF_CMX = 5;
  localparam int DC_POWER = 6;
  localparam int DC_OPERATE = 5;
  localparam int DC_DISPLAY_DATA_ENABLE = 4;
  localparam int WC_AB = 0;
  localparam int WC_CONN = 1;
  localparam int CK_ON = 0;

  // values after reset
  localparam logic [7:0] PIN_FUNC_RST = 8'h00;
  localparam logic [7:0] DRIVE_CTL_RST = 8'h00;
  localparam logic [7:0] WAVE_CTL_RST = 8'h00;

  // segment select value from which driver groups begin
  localparam logic [3:0] SGS_DRIVER_BASE = 4'h8;
  // highest frame clock choice, eleven in all
  localparam logic [3:0] CKS_MAX = 4'ha;

  // timing: subclock rate and system clock rate
  localparam int SYS_CLK_HZ = 125000000;
  localparam int SUBCLK_HZ = 32768;
  localparam int SUBCLK_DIV_CYC = SYS_CLK_HZ / SUBCLK_HZ;
  // frame clock base is subclock divided by four
  localparam int FRAME_BASE_DIV = 4;

  typedef struct packed {
    logic [1:0] duty;
    logic common_combination;
    logic rsv;
    logic [3:0] segment_pin_select;
  } slcd_pin_func_t;

  typedef struct packed {
    logic rsv;
    logic power;
    logic operate;
    logic display_data_enable;
    logic [3:0] frame_clock_select;
  } slcd_drive_ctl_t;

endpackage : slcd_pkg

// ---- rtl/slcd_ctrl.sv ----
/*
  slcd_ctrl: segment display controller with APB register access,
  sixteen byte display memory, frame scanning and common/segment drive.
  assumes: APB master on clk_sys; pin levels go to an analog drive stage
  outside this block that turns the logic levels into panel voltages.
*/
// Notes on behaviour
// R1 - display contents live in a sixteen byte memory written by software and read by the scanner.
// R2 - unused segment pins can be handed over as port pins in groups of four.
// R3 - eleven frame refresh rates are selectable by the frame clock select field.
// R4 - duty comes from the two bit duty field alone, the combination bit being stored but unused, all ones giving quarter duty with four commons.
// R5 - the segment select field chooses the driver pins, value ten making pins nine to thirty-two drivers.
// R6 - bit six turns on the drive supply and bit five makes the controller operate.
// R7 - bit four enables display data and bits three to zero pick a frame clock derived from the subclock over four.
// R8 - a waveform bit chooses waveform A or B, zero giving A.
// R9 - the controller gets its clock only while its clock-on bit is one.
// R10 - software enables the clock, writes pin function, drive control, waveform and then connection control.
// R11 - each memory byte serves two segment pins, low nibble for one and high nibble for the next, one bit per common.
// R12 - while operating the memory is scanned every frame, common by common, driving each enabled segment from its bit.
`timescale 1ns/1ps
`default_nettype none

module slcd_ctrl
  import slcd_pkg::*;
#(
  parameter int SUBCLK_DIV = slcd_pkg::SUBCLK_DIV_CYC
)
(
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [17:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [slcd_pkg::SEG_PINS-1:0] seg_out, // segment levels
  output logic [slcd_pkg::SEG_PINS-1:0] seg_drive_en, // pin is a driver
  output logic [slcd_pkg::COMMONS-1:0] com_out, // common levels
  output logic [slcd_pkg::COMMONS-1:0] com_sel, // selected common
  output logic drive_power_on, // drive supply switch
  output logic split_res_connect // split resistor connect
);
  import slcd_pkg::*;

  logic rst_meta_ff, rst_sync_ff;
  logic rst_n;
  slcd_pin_func_t pin_func_ff;
  slcd_drive_ctl_t drive_ctl_ff;
  logic waveform_b_ff;
  logic conn_ff;
  logic clk_on_ff;
  logic [7:0] display_data_enable_ram_ff [RAM_BYTES];
  logic [15:0] idx;
  logic wr_acc, rd_acc, idx_ok;
  logic [31:0] nxt_prdata;
  logic [15:0] sub_cnt_ff;
  logic sub_tick;
  logic [1:0] base_cnt_ff;
  logic base_tick;
  logic [10:0] frm_cnt_ff;
  logic [3:0] cks_eff;
  logic step_tick;
  logic running;
  logic [1:0] com_idx_ff;
  logic [1:0] last_com;
  logic polarity_ff;
  logic [7:0] frame_num_ff;
  logic [SEG_PINS-1:0] nxt_seg;
  logic [SEG_PINS-1:0] nxt_seg_en;
  logic [COMMONS-1:0] nxt_com;
  logic [COMMONS-1:0] nxt_sel;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // apb decode, zero wait states
  assign idx = paddr[17:2];
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  always_comb
  begin
    idx_ok = 1'b1;
    nxt_prdata = 32'h0000_0000;
    if (idx == IDX_PIN_FUNC)
    begin
      nxt_prdata = {24'h00_0000, pin_func_ff};
    end
    else if (idx == IDX_DRIVE_CTL)
    begin
      nxt_prdata = {25'h000_0000, drive_ctl_ff[6:0]};
    end
    else if (idx == IDX_WAVE_CTL)
    begin
      nxt_prdata = {30'h0000_0000, conn_ff, waveform_b_ff};
    end
    else if (idx == IDX_CLK_ON)
    begin
      nxt_prdata = {31'h0000_0000, clk_on_ff};
    end
    else if (idx == IDX_STATUS)
    begin
      nxt_prdata = {18'h0_0000, frame_num_ff, 1'b0, running,
                    polarity_ff, 1'b0, com_idx_ff};
    end
    else if (idx >= IDX_RAM_FIRST && idx <= IDX_RAM_LAST)
    begin
      nxt_prdata = {24'h00_0000, display_data_enable_ram_ff[idx[3:0]]}; // R1
    end
    else
    begin
      idx_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      if (rd_acc)
      begin
        prdata <= nxt_prdata;
      end
      pready <= psel && !penable;
      pslverr <= psel && !penable && !idx_ok;
    end
  end

  // module clock gate bit, always writable
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_on_ff <= 1'b0;
    end
    else if (wr_acc && idx == IDX_CLK_ON)
    begin
      clk_on_ff <= pwdata[CK_ON]; // R9
    end
  end

  // control registers only take writes while the module clock is on
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_func_ff <= PIN_FUNC_RST;
      drive_ctl_ff <= DRIVE_CTL_RST;
      waveform_b_ff <= WAVE_CTL_RST[WC_AB];
      conn_ff <= WAVE_CTL_RST[WC_CONN];
    end
    else if (wr_acc && clk_on_ff) // R9
    begin
      if (idx == IDX_PIN_FUNC)
      begin
        pin_func_ff <= slcd_pin_func_t'({pwdata[7:5], 1'b0, pwdata[3:0]}); // R4 R5
      end
      else if (idx == IDX_DRIVE_CTL)
      begin
        drive_ctl_ff <= slcd_drive_ctl_t'({1'b0, pwdata[6:0]}); // R6 R7
      end
      else if (idx == IDX_WAVE_CTL)
      begin
        waveform_b_ff <= pwdata[WC_AB]; // R8
        conn_ff <= pwdata[WC_CONN]; // R10
      end
    end
  end

  // display memory
  always_ff @(posedge clk_sys)
  begin
    if (wr_acc && clk_on_ff && idx >= IDX_RAM_FIRST && idx <= IDX_RAM_LAST)
    begin
      display_data_enable_ram_ff[idx[3:0]] <= pwdata[7:0]; // R1
    end
  end

  assign running = clk_on_ff && drive_ctl_ff.power && drive_ctl_ff.operate; // R6 R9

  // subclock enable from the system clock
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_cnt_ff <= 16'h0000;
    end
    else if (!running || sub_tick)
    begin
      sub_cnt_ff <= 16'h0000;
    end
    else
    begin
      sub_cnt_ff <= sub_cnt_ff + 16'h0001;
    end
  end
  assign sub_tick = running && (sub_cnt_ff == 16'(SUBCLK_DIV - 1));

  // subclock over four
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_cnt_ff <= 2'b00;
    end
    else if (!running)
    begin
      base_cnt_ff <= 2'b00;
    end
    else if (sub_tick)
    begin
      base_cnt_ff <= base_cnt_ff + 2'b01; // R7
    end
  end
  assign base_tick = sub_tick && (base_cnt_ff == 2'(FRAME_BASE_DIV - 1));

  // frame clock select, out-of-range codes clamp to the slowest
  assign cks_eff = (drive_ctl_ff.frame_clock_select > CKS_MAX) ? CKS_MAX : drive_ctl_ff.frame_clock_select; // R3

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frm_cnt_ff <= 11'h000;
    end
    else if (!running)
    begin
      frm_cnt_ff <= 11'h000;
    end
    else if (base_tick)
    begin
      frm_cnt_ff <= frm_cnt_ff + 11'h001;
    end
  end
  // step when the low cks_eff+1 bits of the counter all reach ones
  assign step_tick = base_tick &&
    ((frm_cnt_ff & ((11'h002 << cks_eff) - 11'h001)) ==
     ((11'h002 << cks_eff) - 11'h001)); // R3 R7

  assign last_com = pin_func_ff.duty; // R4

  // common scan and polarity
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      com_idx_ff <= 2'b00;
      polarity_ff <= 1'b0;
      frame_num_ff <= 8'h00;
    end
    else if (!running)
    begin
      com_idx_ff <= 2'b00;
      polarity_ff <= 1'b0;
    end
    // duty shrunk below the scanned common, restart the frame
    else if (com_idx_ff > last_com)
    begin
      com_idx_ff <= 2'b00; // R4
    end
    else if (step_tick)
    begin
      if (com_idx_ff >= last_com)
      begin
        com_idx_ff <= 2'b00; // R12
        frame_num_ff <= frame_num_ff + 8'h01;
        if (waveform_b_ff)
        begin
          polarity_ff <= ~polarity_ff; // R8
        end
      end
      else
      begin
        com_idx_ff <= com_idx_ff + 2'b01; // R12
      end
      if (!waveform_b_ff)
      begin
        polarity_ff <= ~polarity_ff; // R8
      end
    end
  end

  // output patterns for the current common
  always_comb
  begin
    nxt_seg = '0;
    nxt_seg_en = '0;
    nxt_com = '0;
    nxt_sel = '0;
    for (int s = 0; s < SEG_PINS; s++)
    begin
      if (pin_func_ff.segment_pin_select >= SGS_DRIVER_BASE &&
          (s / SEG_GROUP) >= int'(pin_func_ff.segment_pin_select - SGS_DRIVER_BASE))
      begin
        nxt_seg_en[s] = 1'b1; // R2 R5
      end
      if (running && nxt_seg_en[s])
      begin
        nxt_seg[s] = polarity_ff ^ (drive_ctl_ff.display_data_enable &&
          display_data_enable_ram_ff[s / 2][(s % 2) * COMMONS + int'(com_idx_ff)]); // R11 R12 R7
      end
    end
    for (int c = 0; c < COMMONS; c++)
    begin
      if (running && c <= int'(last_com) && com_idx_ff <= last_com)
      begin
        nxt_sel[c] = (c == int'(com_idx_ff)); // R4 R12
        nxt_com[c] = (c == int'(com_idx_ff)) ^ polarity_ff;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seg_out <= '0;
      seg_drive_en <= '0;
      com_out <= '0;
      com_sel <= '0;
      drive_power_on <= 1'b0;
      split_res_connect <= 1'b0;
    end
    else
    begin
      seg_out <= nxt_seg;
      seg_drive_en <= nxt_seg_en; // R2
      com_out <= nxt_com;
      com_sel <= nxt_sel;
      drive_power_on <= clk_on_ff && drive_ctl_ff.power; // R6
      split_res_connect <= clk_on_ff && conn_ff; // R10
    end
  end

endmodule : slcd_ctrl

`default_nettype wire

// ---- bench/slcd_ctrl_checker.sv ----
/* slcd_ctrl_checker: port assertions for slcd_ctrl.
   assumes: bound onto slcd_ctrl, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module slcd_ctrl_checker (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [31:0] seg_out, // segment levels
  input wire logic [31:0] seg_drive_en, // driver pins
  input wire logic [3:0] com_out, // common levels
  input wire logic [3:0] com_sel // scanned common
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic grp_ok;
  always_comb
  begin
    grp_ok = 1'b1;
    for (int g = 0; g < 8; g++)
      grp_ok &= seg_drive_en[4*g +: 4] inside {4'h0, 4'hf};
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence step_s;
    $changed(com_sel) && com_sel != 4'h0 && $past(com_sel) != 4'h0;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_read_byte_only: assert property (pready && !pwrite |-> !(|prdata[31:8]))
    else $error("upper read bits set");
  a_port_pins_low: assert property (!(|(seg_out & ~seg_drive_en)))
    else $error("port pin driven");
  a_groups_of_four: assert property (grp_ok)
    else $error("driver group split");
  a_com_onehot: assert property (com_sel != 4'h0 |-> $onehot(com_sel))
    else $error("common select not one-hot");
  a_com_order: assert property (step_s |->
    com_sel == 4'h1 || com_sel == $past(com_sel) << 1)
    else $error("common order wrong");
  a_step_hold: assert property (step_s |=>
    (!$changed(com_sel) || com_sel == 4'h0)[*6])
    else $error("step too short");
  a_stopped_com_low: assert property (com_sel == 4'h0 |-> com_out == 4'h0)
    else $error("common driven while stopped");
endmodule : slcd_ctrl_checker
bind slcd_ctrl slcd_ctrl_checker chk_u (.clk_sys(clk_sys), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .seg_out(seg_out),
  .seg_drive_en(seg_drive_en), .com_out(com_out), .com_sel(com_sel));
`default_nettype wire

// ---- bench/slcd_panel.sv ----
/* slcd_panel: four-common glass panel, keeps the lit pattern per common.
   assumes: logic levels of slcd_ctrl; lit when segment equals common. */
`timescale 1ns/1ps
`default_nettype none
module slcd_panel (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset, active low
  input wire logic [3:0] com_sel, // scanned common
  input wire logic [3:0] com_out, // common levels
  input wire logic [31:0] seg_out, // segment levels
  input wire logic [31:0] seg_drive_en, // driver pins
  output logic [3:0][31:0] img_ff // lit segments per common
);
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      img_ff <= '0;
    else
      for (int c = 0; c < 4; c++)
        if (com_sel[c])
          img_ff[c] <= seg_drive_en & ~(seg_out ^ {32{com_out[c]}});
endmodule : slcd_panel
`default_nettype wire

// ---- bench/slcd_ctrl_bench.sv ----
/* slcd_ctrl_bench: apb sequences against slcd_ctrl and a panel model.
   assumes: slcd_pkg, slcd_ctrl, slcd_panel and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module slcd_ctrl_bench;
  import slcd_pkg::*;
  localparam int DIV = 1;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, seg_out, seg_drive_en, rd_v;
  logic pready, pslverr, drive_power_on, split_res_connect, err_v;
  logic [3:0] com_out, com_sel;
  logic [3:0][31:0] img;
  logic [7:0] ram [16];
  int n_errors = 0;
  int check_count = 0;
  always #4 clk_sys = ~clk_sys;
  slcd_ctrl #(.SUBCLK_DIV(DIV)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seg_out(seg_out), .seg_drive_en(seg_drive_en), .com_out(com_out),
    .com_sel(com_sel), .drive_power_on(drive_power_on),
    .split_res_connect(split_res_connect));
  slcd_panel panel_u (.clk_sys(clk_sys), .rstn(rstn), .com_sel(com_sel),
    .com_out(com_out), .seg_out(seg_out), .seg_drive_en(seg_drive_en),
    .img_ff(img));
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic [15:0] idx, input logic wr,
    input logic [7:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      n_errors++;
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd_chk(input string what, input logic [15:0] idx,
    input logic [31:0] exp);
    xfer(idx, 1'b0, 8'h0);
    check(what, rd_v, exp);
  endtask : rd_chk
  task automatic wait_com(input logic [3:0] v);
    int n;
    n = 0;
    while (com_sel !== v && n < 40000)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_com
  task automatic wait_chg(output int n);
    logic [3:0] c;
    c = com_sel;
    n = 0;
    while (com_sel === c && n < 40000)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_chg
  task automatic check_img(input logic display_data_enable);
    logic [31:0] e;
    repeat (2)
    begin
      wait_com(4'h8);
      wait_com(4'h1);
    end
    for (int c = 0; c < 4; c++)
    begin
      for (int s = 0; s < 32; s++)
        e[s] = (s >= 8) & display_data_enable & ram[s/2][(s%2)*4+c];
      check("image", img[c], e);
    end
  endtask : check_img
  task automatic pol_chk(input logic flips);
    logic p0;
    wait_com(4'h1);
    p0 = ~com_out[0];
    wait_com(4'h2);
    check("polarity flip", {31'h0, p0 ^ ~com_out[1]}, {31'h0, flips});
  endtask : pol_chk
  task automatic seen_chk(input logic [3:0] exp);
    logic [3:0] seen;
    seen = 4'h0;
    repeat (16) @(posedge clk_sys);
    repeat (100)
    begin
      @(posedge clk_sys);
      seen |= com_sel;
    end
    check("commons", {28'h0, seen}, {28'h0, exp});
  endtask : seen_chk
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    int n;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_chk("pin function", IDX_PIN_FUNC, 32'h0);
    rd_chk("drive control", IDX_DRIVE_CTL, 32'h0);
    xfer(IDX_PIN_FUNC, 1'b1, 8'hea);
    rd_chk("gated write", IDX_PIN_FUNC, 32'h0);
    xfer(16'h0100, 1'b0, 8'h0);
    check("unmapped", {err_v, rd_v[30:0]}, 32'h8000_0000);
    xfer(IDX_CLK_ON, 1'b1, 8'h01);
    xfer(IDX_PIN_FUNC, 1'b1, 8'hea);
    xfer(IDX_DRIVE_CTL, 1'b1, 8'hf2);
    xfer(IDX_WAVE_CTL, 1'b1, 8'h00);
    xfer(IDX_WAVE_CTL, 1'b1, 8'h02);
    rd_chk("pin function", IDX_PIN_FUNC, 32'hea);
    rd_chk("drive control", IDX_DRIVE_CTL, 32'h72);
    check("supply", {drive_power_on, split_res_connect}, 32'h3);
    for (int i = 0; i < 16; i++)
    begin
      ram[i] = 8'(i * 29 + 3);
      xfer(IDX_RAM_FIRST + 16'(i), 1'b1, ram[i]);
    end
    for (int i = 0; i < 16; i++)
      rd_chk("ram", IDX_RAM_FIRST + 16'(i), {24'h0, ram[i]});
    for (int s = 0; s < 16; s++)
    begin
      xfer(IDX_PIN_FUNC, 1'b1, 8'he0 | 8'(s));
      repeat (3) @(posedge clk_sys);
      check("drivers", seg_drive_en,
        s < 8 ? 32'h0 : 32'hffff_ffff << (4 * (s - 8)));
    end
    xfer(IDX_PIN_FUNC, 1'b1, 8'hea);
    xfer(IDX_DRIVE_CTL, 1'b1, 8'h70);
    seen_chk(4'hf);
    check_img(1'b1);
    pol_chk(1'b1);
    xfer(IDX_WAVE_CTL, 1'b1, 8'h03);
    check_img(1'b1);
    pol_chk(1'b0);
    xfer(IDX_DRIVE_CTL, 1'b1, 8'h60);
    check_img(1'b0);
    xfer(IDX_PIN_FUNC, 1'b1, 8'h4a);
    seen_chk(4'h3);
    xfer(IDX_PIN_FUNC, 1'b1, 8'hea);
    for (int k = 0; k < 12; k++)
    begin
      xfer(IDX_DRIVE_CTL, 1'b1, 8'h70 | 8'(k));
      wait_chg(n);
      wait_chg(n);
      check("step", n, 32'(4 * DIV) << ((k > 10 ? 10 : k) + 1));
    end
    conclude();
  end
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end
endmodule : slcd_ctrl_bench
`default_nettype wire
